// >>> logic/pcc_clock_control.sv
`timescale 1ns/100ps
module pcc_clock_control (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // control register port
  input wire logic reg_sel_i,
  input wire logic reg_wr_i,
  input wire logic [pcc_pkg::CTRL_W-1:0] reg_wdata_i,
  output logic [pcc_pkg::CTRL_W-1:0] reg_rdata_o,
  // pins
  input wire logic external_clock_input_i,
  input wire logic pll_init_pin_i,
  output logic clock_output_pin_o,
  // processing state from the core
  input wire logic stop_state_i,
  // core clock and status
  output logic core_tick_o,
  output logic pll_locked_o,
  output logic low_skew_o,
  // analog controls
  output logic pll_power_o,
  output logic osc_enable_o,
  output logic osc_gain_reduced_o,
  output logic crystal_drive_disable_o
);
  import pcc_pkg::*;

  // register fields
  logic [PD_W-1:0] predivider_field_q;
  logic clock_output_disable_q;
  logic pll_enable_q;
  logic stop_state_retention_q;
  logic crystal_drive_disable_q;
  logic crystal_range_low_q;
  logic [LPD_W-1:0] low_power_divide_field_q;
  logic [MF_W-1:0] multiplier_field_q;

  // pin synchronisers
  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_s3_q;
  logic init_s1_q;
  logic init_s2_q;
  logic ext_rise;

  // power sequencing
  pcc_pwr_t pwr_q;
  pcc_pwr_t pwr_d;
  logic [OSC_W-1:0] osc_cnt_q;
  logic pll_run;
  logic pen_prev_q;

  // lock and frequency synthesis
  logic wr_en;
  logic loop_change;
  logic lock_restart;
  logic locked;
  logic [CREDIT_W-1:0] credit_q;
  logic [CREDIT_W-1:0] credit_add;
  logic [CREDIT_W-1:0] divisor;
  logic credit_emit;
  logic src_tick;
  logic running;
  logic phase_q;

  // two-stage synchronisers, third stage only for the input edge
  always_ff @(posedge clk_i) begin
    ext_s1_q <= external_clock_input_i;
    ext_s2_q <= ext_s1_q;
    ext_s3_q <= ext_s2_q;
  end

  always_ff @(posedge clk_i) begin
    init_s1_q <= pll_init_pin_i;
    init_s2_q <= init_s1_q;
  end

  assign ext_rise = ext_s2_q & ~ext_s3_q;

  // register write strobe
  assign wr_en = reg_sel_i & reg_wr_i;

  // predivider: loop field, reset to its preset
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      predivider_field_q <= PD_RST;
    end else if (wr_en) begin
      predivider_field_q <= reg_wdata_i[PD_LSB +: PD_W];
    end
  end

  // multiplier: loop field, reset to its preset
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      multiplier_field_q <= MF_RST;
    end else if (wr_en) begin
      multiplier_field_q <= reg_wdata_i[MF_LSB +: MF_W];
    end
  end

  // pll enable: follows the init pin while reset is held
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pll_enable_q <= init_s2_q;
    end else if (wr_en) begin
      pll_enable_q <= reg_wdata_i[PEN_BIT];
    end
  end

  // clock output disable bit
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      clock_output_disable_q <= COD_RST;
    end else if (wr_en) begin
      clock_output_disable_q <= reg_wdata_i[COD_BIT];
    end
  end

  // stop state retention bit
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      stop_state_retention_q <= RET_RST;
    end else if (wr_en) begin
      stop_state_retention_q <= reg_wdata_i[RET_BIT];
    end
  end

  // crystal drive and range bits
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      crystal_drive_disable_q <= XDD_RST;
      crystal_range_low_q <= XRL_RST;
    end else if (wr_en) begin
      crystal_drive_disable_q <= reg_wdata_i[XDD_BIT];
      crystal_range_low_q <= reg_wdata_i[XRL_BIT];
    end
  end

  // low-power divider field, outside the loop
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      low_power_divide_field_q <= LPD_RST;
    end else if (wr_en) begin
      low_power_divide_field_q <= reg_wdata_i[LPD_LSB +: LPD_W];
    end
  end

  // read image of the register, registered
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= {predivider_field_q, clock_output_disable_q, pll_enable_q,
                      stop_state_retention_q, crystal_drive_disable_q, crystal_range_low_q,
                      low_power_divide_field_q, multiplier_field_q};
    end
  end

  // stop sequencing: next state
  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      PCC_RUN: begin
        if (stop_state_i) begin
          pwr_d = stop_state_retention_q ? PCC_STOP_KEEP : PCC_STOP_OFF;
        end
      end
      PCC_STOP_KEEP: begin
        if (!stop_state_i) begin
          pwr_d = PCC_RUN;
        end
      end
      PCC_STOP_OFF: begin
        if (!stop_state_i) begin
          pwr_d = PCC_OSC_START;
        end
      end
      PCC_OSC_START: begin
        if (osc_cnt_q == '0) begin
          pwr_d = PCC_RUN;
        end
      end
      default: begin
        pwr_d = PCC_RUN;
      end
    endcase
  end

  // stop sequencing: state register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pwr_q <= PCC_RUN;
    end else begin
      pwr_q <= pwr_d;
    end
  end

  // oscillator restart count, loaded while everything is off
  always_ff @(posedge clk_i) begin
    if (srst_i || pwr_q == PCC_STOP_OFF) begin
      osc_cnt_q <= OSC_W'(OSC_START_CYCLES);
    end else if (pwr_q == PCC_OSC_START && osc_cnt_q != '0) begin
      osc_cnt_q <= osc_cnt_q - OSC_W'(1);
    end
  end

  // pll powered only when enabled and not shut down by stop
  assign pll_run = pll_enable_q & (pwr_q == PCC_RUN || pwr_q == PCC_STOP_KEEP);

  // rising edge of the enable bit also needs a fresh lock
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pen_prev_q <= 1'b0;
    end else begin
      pen_prev_q <= pll_enable_q;
    end
  end

  // only a changed predivider or multiplier disturbs the loop
  assign loop_change = wr_en &&
    (reg_wdata_i[PD_LSB +: PD_W] != predivider_field_q ||
     reg_wdata_i[MF_LSB +: MF_W] != multiplier_field_q);

  assign lock_restart = loop_change | (pll_enable_q & ~pen_prev_q);

  // relock delay timer
  pcc_lock_timer u_lock_timer (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .run_i(pll_run),
    .restart_i(lock_restart),
    .locked_o(locked)
  );

  // pll rate: twice (mf+1) credit per input edge, spent in units of (pdf+1) shifted left by df
  assign credit_add = ext_rise ? CREDIT_W'({multiplier_field_q, 1'b0}) + CREDIT_W'(2) : '0;
  assign divisor = CREDIT_W'({4'h0, predivider_field_q} + 8'h01) << low_power_divide_field_q;
  assign credit_emit = (credit_q >= divisor);

  // credit accumulator, emptied whenever the loop is not locked
  always_ff @(posedge clk_i) begin
    if (srst_i || !locked) begin
      credit_q <= '0;
    end else if (credit_q >= CREDIT_CAP) begin
      credit_q <= credit_q - (credit_emit ? divisor : '0);
    end else begin
      credit_q <= credit_q + credit_add - (credit_emit ? divisor : '0);
    end
  end

  // source of the output stage: input edge or pll ticks
  assign src_tick = pll_enable_q ? (locked & credit_emit) : ext_rise;

  // core clock runs outside stop and oscillator start
  assign running = (pwr_q == PCC_RUN);

  // output stage halves the source rate
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      phase_q <= 1'b0;
    end else if (running && src_tick) begin
      phase_q <= ~phase_q;
    end
  end

  // core tick on the rising phase of the output stage
  assign core_tick_o = running & src_tick & ~phase_q;

  // clock output pin from the same phase flop
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      clock_output_pin_o <= 1'b0;
    end else if (clock_output_disable_q) begin
      clock_output_pin_o <= 1'b1;
    end else if (!running) begin
      clock_output_pin_o <= 1'b0;
    end else if (src_tick) begin
      clock_output_pin_o <= ~phase_q;
    end
  end

  // lock status output
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pll_locked_o <= 1'b0;
    end else begin
      pll_locked_o <= locked;
    end
  end

  // low skew only for small multipliers with the loop locked
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      low_skew_o <= 1'b0;
    end else begin
      low_skew_o <= pll_enable_q & locked &
        (({1'b0, multiplier_field_q} + 13'h0001) < 13'(SKEW_MF_LIMIT));
    end
  end

  // pll and oscillator power, oscillator one cycle early
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pll_power_o <= 1'b0;
      osc_enable_o <= 1'b1;
    end else begin
      pll_power_o <= pll_run;
      osc_enable_o <= (pwr_d != PCC_STOP_OFF);
    end
  end

  // crystal amplifier controls
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      osc_gain_reduced_o <= 1'b0;
      crystal_drive_disable_o <= 1'b0;
    end else begin
      osc_gain_reduced_o <= crystal_range_low_q;
      crystal_drive_disable_o <= crystal_drive_disable_q;
    end
  end

endmodule : pcc_clock_control

// >>> logic/pcc_lock_timer.sv
`timescale 1ns/100ps
// lock indication: drops on restart or power off, returns after the relock delay
module pcc_lock_timer (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // control
  input wire logic run_i,
  input wire logic restart_i,
  // status
  output logic locked_o
);
  import pcc_pkg::*;

  logic [RELOCK_W-1:0] cnt_q;

  // relock countdown, reloaded on every restart
  always_ff @(posedge clk_i) begin
    if (srst_i || !run_i || restart_i) begin
      cnt_q <= RELOCK_W'(RELOCK_CYCLES);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - RELOCK_W'(1);
    end
  end

  // lock flag follows the counter
  always_ff @(posedge clk_i) begin
    if (srst_i || !run_i || restart_i) begin
      locked_o <= 1'b0;
    end else begin
      locked_o <= (cnt_q == '0);
    end
  end

endmodule : pcc_lock_timer

// >>> logic/pcc_pkg.sv
// shared constants for the pll clock control block
package pcc_pkg;

  // clock of the control logic
  localparam int unsigned CLK_HZ = 10_000_000;

  // control register width and field positions
  localparam int unsigned CTRL_W = 24;
  localparam int unsigned PD_LSB = 20;
  localparam int unsigned PD_W = 4;
  localparam int unsigned COD_BIT = 19;
  localparam int unsigned PEN_BIT = 18;
  localparam int unsigned RET_BIT = 17;
  localparam int unsigned XDD_BIT = 16;
  localparam int unsigned XRL_BIT = 15;
  localparam int unsigned LPD_LSB = 12;
  localparam int unsigned LPD_W = 3;
  localparam int unsigned MF_LSB = 0;
  localparam int unsigned MF_W = 12;

  // values after reset (presets are implementation values, plain defaults)
  localparam logic [PD_W-1:0] PD_RST = 4'h0;
  localparam logic COD_RST = 1'b0;
  localparam logic RET_RST = 1'b0;
  localparam logic XDD_RST = 1'b0;
  localparam logic XRL_RST = 1'b0;
  localparam logic [LPD_W-1:0] LPD_RST = 3'h0;
  localparam logic [MF_W-1:0] MF_RST = 12'h000;

  // relock delay, counted in clock cycles, at most 1000
  localparam int unsigned RELOCK_MAX_CYCLES = 1000;
  localparam int unsigned RELOCK_CYCLES = 256;
  localparam int unsigned RELOCK_W = 10;

  // oscillator restart time after a stop with everything off
  localparam int unsigned OSC_START_US = 10;
  localparam int unsigned OSC_START_CYCLES = (OSC_START_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int unsigned OSC_W = 8;

  // multiplier values below this keep skew low
  localparam int unsigned SKEW_MF_LIMIT = 5;

  // width of the frequency credit accumulator and its saturation point
  localparam int unsigned CREDIT_W = 16;
  localparam logic [CREDIT_W-1:0] CREDIT_CAP = 16'hC000;

  // power and stop sequencing states
  typedef enum logic [1:0] {
    PCC_RUN = 2'b00,
    PCC_STOP_KEEP = 2'b01,
    PCC_STOP_OFF = 2'b10,
    PCC_OSC_START = 2'b11
  } pcc_pwr_t;

endpackage : pcc_pkg

// >>> verification/pcc_clock_control_checker.sv
`timescale 1ns/100ps
// watches the register port, the clock pin and the power outputs
module pcc_clock_control_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // register port
  input wire logic reg_sel_i,
  input wire logic reg_wr_i,
  input wire logic [pcc_pkg::CTRL_W-1:0] reg_wdata_i,
  input wire logic [pcc_pkg::CTRL_W-1:0] reg_rdata_o,
  // pins and status
  input wire logic clock_output_pin_o,
  input wire logic stop_state_i,
  input wire logic pll_locked_o,
  input wire logic low_skew_o,
  input wire logic pll_power_o,
  input wire logic osc_enable_o,
  input wire logic osc_gain_reduced_o,
  input wire logic crystal_drive_disable_o
);
  import pcc_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic wr;
  logic pin_q;
  logic [7:0] hold_q;
  assign wr = reg_sel_i && reg_wr_i;
  // cycles the pin stood still while pll is off and output enabled
  always_ff @(posedge clk_i) begin
    pin_q <= clock_output_pin_o;
    if (srst_i || reg_rdata_o[18] || reg_rdata_o[19] || stop_state_i || pin_q != clock_output_pin_o) begin
      hold_q <= 8'h00;
    end else begin
      hold_q <= hold_q + 8'h01;
    end
  end
  a_write_readback: assert property (wr |-> ##2 reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("register readback differs");
  a_loop_drops_lock: assert property (wr && !$past(wr) && (reg_wdata_i[23:20] != reg_rdata_o[23:20]
    || reg_wdata_i[11:0] != reg_rdata_o[11:0]) |-> ##2 !pll_locked_o) else $error("lock kept after loop change");
  a_relock_bound: assert property ($fell(pll_locked_o) |-> ##[1:1000] pll_locked_o)
    else $error("no relock in time");
  a_lpd_keeps_lock: assert property (wr && !$past(wr) && pll_locked_o && pll_power_o && !stop_state_i
    && reg_wdata_i[23:18] == reg_rdata_o[23:18] && reg_wdata_i[11:0] == reg_rdata_o[11:0]
    |-> ##1 pll_locked_o [*3]) else $error("divider change lost lock");
  a_cod_pin_high: assert property (reg_rdata_o[19] && $past(reg_rdata_o[19]) |-> clock_output_pin_o)
    else $error("disabled clock pin not high");
  a_pin_keeps_running: assert property (hold_q < 8'd200)
    else $error("clock pin stopped toggling");
  a_stop_all_off: assert property (!reg_rdata_o[17] && stop_state_i [*3] |-> !osc_enable_o && !pll_power_o)
    else $error("stop left oscillator or pll on");
  a_stop_retained: assert property (reg_rdata_o[17] && stop_state_i [*3] |-> osc_enable_o
    && pll_power_o == reg_rdata_o[18]) else $error("stop retention wrong");
  a_crystal_copy: assert property (osc_gain_reduced_o == reg_rdata_o[15]
    && crystal_drive_disable_o == reg_rdata_o[16]) else $error("crystal control differs");
  a_low_skew_cond: assert property (low_skew_o |-> reg_rdata_o[18] && pll_locked_o && reg_rdata_o[11:0] < 12'h004)
    else $error("low skew flagged wrongly");
endmodule : pcc_clock_control_checker

bind pcc_clock_control pcc_clock_control_checker chk_u (.clk_i, .srst_i, .reg_sel_i, .reg_wr_i, .reg_wdata_i,
  .reg_rdata_o, .clock_output_pin_o, .stop_state_i, .pll_locked_o, .low_skew_o, .pll_power_o, .osc_enable_o,
  .osc_gain_reduced_o, .crystal_drive_disable_o);

// >>> verification/pcc_clock_control_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("wrong value at %0t: %h vs %h", $time, a, b); end end
// register driven tests of the clock control block
module pcc_clock_control_tb;
  import pcc_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic sel = 1'b0;
  logic wr = 1'b0;
  logic [CTRL_W-1:0] wdata = 24'h000000;
  logic [CTRL_W-1:0] rdata;
  logic init = 1'b1;
  logic stop = 1'b0;
  logic [2:0] ecnt = 3'h0;
  logic pin, tick, locked, skew, pwr, osc, gain, xdd;
  int n_mismatch = 0;
  int n_checks = 0;
  int t, k;
  // clock, external input at an eighth of it
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  always @(negedge clk_i) ecnt <= ecnt + 3'h1;
  pcc_clock_control dut_u (.clk_i(clk_i), .srst_i(srst_i), .reg_sel_i(sel), .reg_wr_i(wr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .external_clock_input_i(ecnt[2]), .pll_init_pin_i(init), .clock_output_pin_o(pin),
    .stop_state_i(stop), .core_tick_o(tick), .pll_locked_o(locked), .low_skew_o(skew), .pll_power_o(pwr),
    .osc_enable_o(osc), .osc_gain_reduced_o(gain), .crystal_drive_disable_o(xdd));
  // one register write, then the image checked
  task automatic wreg(input logic [CTRL_W-1:0] d);
    sel = 1'b1;
    wr = 1'b1;
    wdata = d;
    @(negedge clk_i);
    sel = 1'b0;
    wr = 1'b0;
    repeat (2) @(negedge clk_i);
    `CHK(rdata, d)
  endtask : wreg
  // pin toggles and core ticks over n cycles
  task automatic watch(input int n);
    logic p;
    t = 0;
    k = 0;
    p = pin;
    repeat (n) begin
      @(negedge clk_i);
      if (pin !== p) t++;
      if (tick === 1'b1) k++;
      p = pin;
    end
  endtask : watch
  task automatic wait_lock();
    for (int i = 0; i < 1000 && locked !== 1'b1; i++) @(negedge clk_i);
    `CHK(locked, 1'b1)
  endtask : wait_lock
  task automatic hold_stop(input logic po, input logic oo);
    stop = 1'b1;
    repeat (20) @(negedge clk_i);
    `CHK({pwr, osc}, {po, oo})
    stop = 1'b0;
    wait_lock();
  endtask : hold_stop
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  // watchdog
  initial begin
    #2000000;
    n_mismatch++;
    final_report();
  end
  // main sequence
  initial begin
    repeat (12) @(negedge clk_i);
    srst_i = 1'b0;
    @(negedge clk_i);
    `CHK(rdata, 24'h040000)
    $display("reset image done");
    wreg(24'h000000);
    watch(80);
    `CHK(t >= 9 && t <= 11, 1'b1)
    `CHK(k >= 4 && k <= 6, 1'b1)
    wreg(24'h080000);
    watch(40);
    `CHK({pin, t[7:0]}, 9'h100)
    $display("clock pin done");
    wreg(24'h040003);
    `CHK(locked, 1'b0)
    wait_lock();
    @(negedge clk_i);
    `CHK(skew, 1'b1)
    wreg(24'h041003);
    watch(16);
    watch(80);
    `CHK(t >= 38 && t <= 42, 1'b1)
    `CHK(k >= 19 && k <= 21 && locked === 1'b1, 1'b1)
    wreg(24'h047003);
    `CHK(locked, 1'b1)
    wreg(24'h1D8004);
    `CHK({locked, skew, gain, xdd}, 4'h3)
    wait_lock();
    $display("lock tests done");
    wreg(24'h040000);
    wait_lock();
    hold_stop(1'b0, 1'b0);
    wreg(24'h020000);
    stop = 1'b1;
    repeat (20) @(negedge clk_i);
    `CHK({pwr, osc}, 2'b01)
    stop = 1'b0;
    wreg(24'h060000);
    wait_lock();
    hold_stop(1'b1, 1'b1);
    $display("stop tests done");
    init = 1'b0;
    srst_i = 1'b1;
    repeat (12) @(negedge clk_i);
    srst_i = 1'b0;
    @(negedge clk_i);
    `CHK({rdata, pwr, osc}, 26'h0000001)
    watch(80);
    `CHK(t >= 9 && t <= 11, 1'b1)
    $display("reset pin test done");
    final_report();
  end
endmodule : pcc_clock_control_tb
